// ===== core/bitops_pkg.sv
// package: register map, status flag positions, opcodes and structs for the bit/flag unit
package bitops_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] CMD_OFS = 8'h00;    // command: op, reg index, bit select
  localparam logic [7:0] STATUS_OFS = 8'h04; // status flags register, read/write
  localparam logic [7:0] WREG_OFS = 8'h08;   // working register window, index in address bits [4:2]
  localparam logic [7:0] EVENT_OFS = 8'h28;  // combined count of sleep/watchdog/break requests
  localparam logic [7:0] WREG_SPAN = 8'h20;  // eight words of working registers

  // ----------------------------------------
  // command field layout
  // ----------------------------------------
  localparam int CMD_OP_LSB = 0;   // opcode [4:0]
  localparam int CMD_REG_LSB = 8;  // register index [10:8]
  localparam int CMD_BIT_LSB = 16; // bit / flag select [18:16]

  // ----------------------------------------
  // status flag positions
  // ----------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ----------------------------------------
  // reset values and sizes
  // ----------------------------------------
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam int WREG_COUNT = 8;
  localparam logic [31:0] READ_DEFAULT = 32'h00000000;

  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ROTATE_RIGHT = 5'h01, OP_ARITH_SHIFT = 5'h02, OP_SWAP = 5'h03,
    OP_FLAG_SET = 5'h04, OP_FLAG_CLEAR = 5'h05, OP_BIT_TO_FLAG = 5'h06,
    OP_FLAG_TO_BIT = 5'h07, OP_SET_C = 5'h08, OP_CLR_C = 5'h09, OP_SET_Z = 5'h0A,
    OP_CLR_Z = 5'h0B, OP_SET_N = 5'h0C, OP_CLR_N = 5'h0D, OP_SET_V = 5'h0E,
    OP_CLR_V = 5'h0F, OP_SET_S = 5'h10, OP_CLR_S = 5'h11, OP_SET_H = 5'h12,
    OP_CLR_H = 5'h13, OP_SET_T = 5'h14, OP_CLR_T = 5'h15, OP_SET_I = 5'h16,
    OP_CLR_I = 5'h17, OP_SLEEP = 5'h18, OP_WDOG = 5'h19, OP_BREAK = 5'h1A
  } op_t;

  // one decoded instruction
  typedef struct packed {
    op_t op;
    logic [2:0] regSel;
    logic [2:0] bitSel;
  } instr_t;

  // result of the datapath
  typedef struct packed {
    logic [7:0] data;
    logic dataWe;
    logic [7:0] flags;
    logic sleepReq;
    logic wdogReq;
    logic breakReq;
  } result_t;

endpackage

// ===== core/bit_alu.sv
// combinational shift, swap, bit transfer and flag datapath
`timescale 1ns/10ps
module bit_alu
  import bitops_pkg::*;
(
  // instruction and operands
  input wire bitops_pkg::instr_t instr,
  input wire logic [7:0] operand,
  input wire logic [7:0] flagsIn,
  // outcome
  output bitops_pkg::result_t res
);

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  always_comb begin
    logic [7:0] r;
    logic [7:0] f;
    r = operand;
    f = flagsIn;
    res = '0;
    case (instr.op)
      OP_ROTATE_RIGHT, OP_ARITH_SHIFT: begin
        // bit 7 from carry or kept sign
        if (instr.op == OP_ROTATE_RIGHT) begin
          r = {flagsIn[FLAG_C], operand[7:1]};
        end else begin
          r = {operand[7], operand[7:1]};
        end
        f[FLAG_C] = operand[0];
        f[FLAG_Z] = (r == 8'h00);
        f[FLAG_N] = r[7];
        f[FLAG_V] = r[7] ^ operand[0]; // n xor c
        res.dataWe = 1'b1;
      end
      OP_SWAP: begin
        r = {operand[3:0], operand[7:4]};
        res.dataWe = 1'b1;
      end
      OP_FLAG_SET: f[instr.bitSel] = 1'b1;
      OP_FLAG_CLEAR: f[instr.bitSel] = 1'b0;
      OP_BIT_TO_FLAG: f[FLAG_T] = operand[instr.bitSel];
      OP_FLAG_TO_BIT: begin
        r[instr.bitSel] = flagsIn[FLAG_T];
        res.dataWe = 1'b1;
      end
      OP_SET_C, OP_CLR_C: f[FLAG_C] = ~instr.op[0];
      OP_SET_Z, OP_CLR_Z: f[FLAG_Z] = ~instr.op[0];
      OP_SET_N, OP_CLR_N: f[FLAG_N] = ~instr.op[0];
      OP_SET_V, OP_CLR_V: f[FLAG_V] = ~instr.op[0];
      OP_SET_S, OP_CLR_S: f[FLAG_S] = ~instr.op[0];
      OP_SET_H, OP_CLR_H: f[FLAG_H] = ~instr.op[0];
      OP_SET_T, OP_CLR_T: f[FLAG_T] = ~instr.op[0];
      OP_SET_I, OP_CLR_I: f[FLAG_I] = ~instr.op[0];
      OP_SLEEP: res.sleepReq = 1'b1;
      OP_WDOG: res.wdogReq = 1'b1;
      OP_BREAK: res.breakReq = 1'b1;
      default: f = flagsIn; // no operation
    endcase
    res.data = r;
    res.flags = f;
  end

endmodule

// ===== core/work_regs.sv
// eight-byte working register memory with registered read port
`timescale 1ns/10ps
module work_regs
  import bitops_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // write port
  input wire logic wrEn,
  input wire logic [2:0] wrIdx,
  input wire logic [7:0] wrData,
  // registered read port
  input wire logic [2:0] rdIdx,
  output logic [7:0] rdData
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] mem_reg [WREG_COUNT]; // working bytes

  // per-entry write with reset
  genvar g;
  generate
    for (g = 0; g < WREG_COUNT; g++) begin : gen_entry
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          mem_reg[g] <= WREG_RST;
        end else if (wrEn && wrIdx == 3'(g)) begin
          mem_reg[g] <= wrData;
        end
      end
    end
  endgenerate

  // read data from a flop
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdData <= WREG_RST;
    end else begin
      rdData <= mem_reg[rdIdx];
    end
  end

endmodule

// ===== core/bit_flag_unit.sv
// top: AHB-Lite slave driving the shift, bit transfer and flag execution unit
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
module bit_flag_unit
  import bitops_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // system requests and flags
  output logic sleepReq,
  output logic wdogRestart,
  output logic debugBreak,
  output logic [7:0] statusFlags
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum {ST_IDLE, ST_FETCH, ST_EXEC, ST_READ} state_t;
  state_t state_reg; // transfer sequencer
  logic [7:0] addr_reg; // latched address
  logic write_reg; // latched direction
  logic [7:0] status_flags_register; // c z n v s h t i
  instr_t instr_reg; // pending instruction
  logic [7:0] eventCount_reg; // combined count of side requests
  logic [2:0] rdIdx; // memory read index
  logic [7:0] rdData; // memory read data
  logic memWe; // memory write strobe
  logic [2:0] memIdx; // memory write index
  logic [7:0] memData; // memory write data
  result_t res; // datapath outcome

  // ----------------------------------------
  // datapath and memory
  // ----------------------------------------
  bit_alu u_alu (
    .instr(instr_reg),
    .operand(rdData),
    .flagsIn(status_flags_register),
    .res(res)
  );

  work_regs u_regs (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wrEn(memWe),
    .wrIdx(memIdx),
    .wrData(memData),
    .rdIdx(rdIdx),
    .rdData(rdData)
  );

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  logic takeReq; // valid address phase
  logic dataPhase; // data phase of the latched transfer, read or write
  logic isWreg; // address hits register window
  assign takeReq = hsel && hready && htrans[1] && state_reg == ST_IDLE;
  assign dataPhase = state_reg == ST_FETCH;
  assign isWreg = addr_reg >= WREG_OFS && addr_reg < WREG_OFS + WREG_SPAN;

  // memory port steering: bus writes vs instruction results
  always_comb begin
    memWe = 1'b0;
    memIdx = addr_reg[4:2];
    memData = hwdata[7:0];
    rdIdx = instr_reg.regSel;
    if (dataPhase && write_reg && isWreg) begin
      memWe = 1'b1; // bus writes a working byte
    end else if (state_reg == ST_EXEC && res.dataWe) begin
      memWe = 1'b1;
      memIdx = instr_reg.regSel;
      memData = res.data;
    end
    if (dataPhase && !write_reg) begin
      rdIdx = addr_reg[4:2];
    end else if (dataPhase && addr_reg == CMD_OFS) begin
      // fetch the operand of the command now arriving, not the previous one
      rdIdx = hwdata[CMD_REG_LSB +: 3];
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      addr_reg <= 8'h00;
      write_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (takeReq) begin
            state_reg <= ST_FETCH;
            addr_reg <= haddr[7:0];
            write_reg <= hwrite;
          end
        end
        ST_FETCH: begin
          // commands wait for the operand read
          if (write_reg && addr_reg == CMD_OFS) begin
            state_reg <= ST_EXEC;
          end else if (!write_reg) begin
            state_reg <= ST_READ;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_EXEC: state_reg <= ST_IDLE;
        ST_READ: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // instruction latch
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      instr_reg <= '0;
    end else if (dataPhase && write_reg && addr_reg == CMD_OFS) begin
      instr_reg.op <= op_t'(hwdata[CMD_OP_LSB +: 5]);
      instr_reg.regSel <= hwdata[CMD_REG_LSB +: 3];
      instr_reg.bitSel <= hwdata[CMD_BIT_LSB +: 3];
    end
  end

  // ----------------------------------------
  // status flags: one clock per instruction
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_flags_register <= STATUS_RST;
    end else if (state_reg == ST_EXEC) begin
      status_flags_register <= res.flags;
    end else if (dataPhase && write_reg && addr_reg == STATUS_OFS) begin
      status_flags_register <= hwdata[7:0];
    end
  end

  // ----------------------------------------
  // side requests: one-cycle pulses
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sleepReq <= 1'b0;
      wdogRestart <= 1'b0;
      debugBreak <= 1'b0;
      eventCount_reg <= 8'h00;
    end else begin
      sleepReq <= state_reg == ST_EXEC && res.sleepReq;
      wdogRestart <= state_reg == ST_EXEC && res.wdogReq;
      debugBreak <= state_reg == ST_EXEC && res.breakReq;
      if (state_reg == ST_EXEC && (res.sleepReq || res.wdogReq || res.breakReq)) begin
        eventCount_reg <= eventCount_reg + 8'h01;
      end
    end
  end

  // mirror of the flags
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      statusFlags <= STATUS_RST;
    end else begin
      statusFlags <= status_flags_register;
    end
  end

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hrdata <= READ_DEFAULT;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      hreadyout <= !(takeReq || state_reg == ST_FETCH);
      if (state_reg == ST_FETCH && !write_reg) begin
        if (addr_reg == STATUS_OFS) begin
          hrdata <= {24'h000000, status_flags_register};
        end else if (addr_reg == CMD_OFS) begin
          hrdata <= {13'h0000, instr_reg.bitSel, 5'h00, instr_reg.regSel, 3'h0, instr_reg.op};
        end else if (addr_reg == EVENT_OFS) begin
          hrdata <= {24'h000000, eventCount_reg};
        end else begin
          hrdata <= READ_DEFAULT;
        end
      end else if (state_reg == ST_READ && isWreg) begin
        hrdata <= {24'h000000, rdData};
      end
    end
  end

endmodule

// ===== tb/bit_flag_unit_monitor.sv
// checker of bus timing, request pulses and flag stability at the unit ports
`timescale 1ns/10ps
module bit_flag_unit_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // ahb-lite signals
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // system requests and flags
  input wire logic sleepReq,
  input wire logic wdogRestart,
  input wire logic debugBreak,
  input wire logic [7:0] statusFlags
);
  // ----------------------------------------
  // clocking and helpers
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire taken = hsel && hready && htrans[1] && hreadyout; // accepted address phase
  wire anyReq = sleepReq || wdogRestart || debugBreak; // some request pulse

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_wait; taken |=> !hreadyout ##[1:2] hreadyout; endproperty
  a_wait: assert property (p_wait) else $error("data phase length wrong");
  property p_pulse; anyReq |=> !anyReq; endproperty
  a_pulse: assert property (p_pulse) else $error("request pulse too long");
  property p_excl; $onehot0({sleepReq, wdogRestart, debugBreak}); endproperty
  a_excl: assert property (p_excl) else $error("two requests at once");
  property p_reqrdy; anyReq |-> hreadyout; endproperty
  a_reqrdy: assert property (p_reqrdy) else $error("request outside end of command");
  property p_sleep; sleepReq |-> $stable(statusFlags) ##1 $stable(statusFlags); endproperty
  a_sleep: assert property (p_sleep) else $error("flags moved on sleep");
  property p_wdog; wdogRestart |-> $stable(statusFlags) ##1 $stable(statusFlags); endproperty
  a_wdog: assert property (p_wdog) else $error("flags moved on watchdog");
  property p_brk; debugBreak |-> $stable(statusFlags) ##1 $stable(statusFlags); endproperty
  a_brk: assert property (p_brk) else $error("flags moved on break");
  property p_hold; !$stable(statusFlags) |-> !$past(hreadyout) || !$past(hreadyout, 2); endproperty
  a_hold: assert property (p_hold) else $error("flags changed while bus idle");
endmodule

bind bit_flag_unit bit_flag_unit_monitor u_mon (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel),
  .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .sleepReq(sleepReq),
  .wdogRestart(wdogRestart), .debugBreak(debugBreak), .statusFlags(statusFlags));

// ===== tb/bit_flag_unit_bench.sv
// self-checking bench driving the unit over ahb-lite
`timescale 1ns/10ps
module bit_flag_unit_bench;
  import bitops_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic mclk = 0, sys_rst = 1, hsel = 0, hwrite = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, sleepReq, wdogRestart, debugBreak;
  logic [7:0] statusFlags;
  int error_cnt = 0, tests_run = 0;
  int pc[3] = '{0, 0, 0}; // sleep, watchdog, break pulse counts
  always #2 mclk = ~mclk;
  bit_flag_unit uut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleepReq(sleepReq),
    .wdogRestart(wdogRestart), .debugBreak(debugBreak), .statusFlags(statusFlags));
  // pulse counters
  always @(posedge mclk) begin
    if (sleepReq === 1'b1) pc[0]++;
    if (wdogRestart === 1'b1) pc[1]++;
    if (debugBreak === 1'b1) pc[2]++;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one single transfer, entered just after a rising edge
  task xfer(input logic w, input logic [31:0] a, d);
    hsel <= 1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // byte address of working register r, word r minus two of the window, wrapping within the eight
  function logic [31:0] wa(input logic [2:0] r);
    return 32'(WREG_OFS) + 32'({r - 3'h2, 2'b00});
  endfunction
  // load register and flags, execute, compare both
  task run(input op_t op, input logic [2:0] r, b, input logic [7:0] st, d, es, ed);
    xfer(1, wa(r), {24'h0, d});
    xfer(1, 32'(STATUS_OFS), {24'h0, st});
    xfer(1, 32'(CMD_OFS), (32'(op) << CMD_OP_LSB) | (32'(r) << CMD_REG_LSB)
      | (32'(b) << CMD_BIT_LSB));
    xfer(0, wa(r), 32'h0);
    chk("wreg", {24'h0, ed}, rd);
    xfer(0, 32'(STATUS_OFS), 32'h0);
    chk("status", {24'h0, es}, rd);
    chk("statusFlags", {24'h0, es}, {24'h0, statusFlags});
  endtask
  // shift and swap with expectation worked out here
  task sh(input op_t op, input logic [7:0] st, d);
    logic [7:0] res, f;
    res = (op == OP_SWAP) ? {d[3:0], d[7:4]} : {(op == OP_ROTATE_RIGHT) ? st[0] : d[7], d[7:1]};
    f = (op == OP_SWAP) ? st : {st[7:4], res[7] ^ d[0], res[7], res == 8'h00, d[0]};
    run(op, 3'h5, 3'h0, st, d, f, res);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("flags port", {24'h0, STATUS_RST}, {24'h0, statusFlags});
    for (int r = 0; r < WREG_COUNT; r++) begin
      xfer(0, wa(3'(r)), 32'h0);
      chk("wreg reset", {24'h0, WREG_RST}, rd);
    end
    xfer(1, 32'h3C, 32'hFF); // unmapped write ignored
    xfer(0, 32'h3C, 32'h0);
    chk("unmapped", READ_DEFAULT, rd);
  endtask
  task t_shift;
    sh(OP_ROTATE_RIGHT, 8'h61, 8'h81);
    sh(OP_ROTATE_RIGHT, 8'hFE, 8'h01);
    sh(OP_ARITH_SHIFT, 8'h01, 8'h80);
    sh(OP_ARITH_SHIFT, 8'hF0, 8'h01);
    sh(OP_SWAP, 8'h9B, 8'hA5);
  endtask
  task t_bits;
    logic [7:0] st, d, e;
    for (int b = 0; b < 8; b++) begin
      st = b[0] ? 8'hFF : 8'h00;
      d = 8'hA5;
      // only the transfer flag takes the selected bit
      e = st;
      e[FLAG_T] = d[b];
      run(OP_BIT_TO_FLAG, 3'h1, 3'(b), st, d, e, d);
      st = b[0] ? 8'h40 : 8'hBF;
      d = 8'h5A;
      d[b] = st[6];
      run(OP_FLAG_TO_BIT, 3'h6, 3'(b), st, 8'h5A, st, d);
    end
  endtask
  task t_flags;
    op_t op;
    for (int k = 0; k < 8; k++) begin
      op = op_t'(OP_SET_C + 5'(2 * k));
      run(op, 3'h0, 3'h0, 8'h00, 8'h3C, 8'h01 << k, 8'h3C);
      op = op_t'(OP_CLR_C + 5'(2 * k));
      run(op, 3'h0, 3'h0, 8'hFF, 8'h3C, ~(8'h01 << k), 8'h3C);
      run(OP_FLAG_SET, 3'h2, 3'(k), 8'h00, 8'hC3, 8'h01 << k, 8'hC3);
      run(OP_FLAG_CLEAR, 3'h2, 3'(k), 8'hFF, 8'hC3, ~(8'h01 << k), 8'hC3);
    end
  endtask
  task t_sys;
    op_t ops[4];
    int old[3];
    ops = '{OP_SLEEP, OP_WDOG, OP_BREAK, OP_NOP};
    for (int j = 0; j < 4; j++) begin
      old = pc;
      run(ops[j], 3'h7, 3'h3, 8'hA5, 8'h3C, 8'hA5, 8'h3C);
      for (int i = 0; i < 3; i++) begin
        chk("pulse count", 32'(old[i] + (i == j)), 32'(pc[i]));
      end
    end
    // one request counted per sleep, watchdog and break command
    xfer(0, 32'(EVENT_OFS), 32'h0);
    chk("event count", 32'h3, rd);
    // command word reads back as last written
    xfer(0, 32'(CMD_OFS), 32'h0);
    chk("command", (32'(OP_NOP) << CMD_OP_LSB) | (32'h7 << CMD_REG_LSB)
      | (32'h3 << CMD_BIT_LSB), rd);
  endtask
  // ----------------------------------------
  // verdict and main sequence
  // ----------------------------------------
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #80000;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 0;
    @(posedge mclk);
    t_reset();
    t_shift();
    t_bits();
    t_flags();
    t_sys();
    close_out();
  end
endmodule
